/* core/psw_map.vh */
// Purpose: Constants for the pseudo-static memory write-burst host controller.
// Assumes: Included by the controller and its data memory module.
// Notes: Offsets, fields, the control reset and the divider and guard cycle counts live here.
// Operation
// - Select low while clock idle, then clock.
// - Command bit 47 zero means write.
// - Command bit 46 zero selects memory space.
// - Command bit 45 selects wrapped or linear.
// - Host clocks latency cycles before data.
// - Strobe low one latency, high doubles.
// - Host drives data centred between clock edges.
// - Mask high keeps byte, low stores it.
// - No latency inserted during data phase.
// - Data flows one word per clock cycle.
// - Host ends write raising select, clock idle.
// - Clock may idle while select is high.
// - Deselect between transactions, never back-to-back.
// - Zero latency: no mask, full words written. This controller does not offer zero latency and always drives the mask.
`ifndef PSW_MAP_VH
`define PSW_MAP_VH
// Register offsets of the controller's own register port.
`define PSW_ADDR_CTRL 4'h0
`define PSW_ADDR_ADDR 4'h1
`define PSW_ADDR_STAT 4'h2
`define PSW_ADDR_DATA 4'h3
// Control register fields.
`define PSW_CTRL_GO 0
`define PSW_CTRL_LINEAR 1
`define PSW_CTRL_LAT_LO 4
`define PSW_CTRL_LAT_HI 7
`define PSW_CTRL_LEN_LO 8
`define PSW_CTRL_LEN_HI 15
`define PSW_CTRL_RESET 16'h0060
// Command-address field positions.
`define PSW_CA_DIR 47
`define PSW_CA_SPACE 46
`define PSW_CA_BURST 45
// Status fields.
`define PSW_STAT_BUSY 0
`define PSW_STAT_DOUBLE 1
`define PSW_STAT_DONE 2
// Clock divider: half period of the bus clock in system cycles.
`define PSW_TCK_NS 16
`define PSW_SYS_NS 4
`define PSW_HALF_CYC ((`PSW_TCK_NS / 2) / `PSW_SYS_NS)
// Guard time with the clock idle around select edges, in ns.
`define PSW_GUARD_NS 8
`define PSW_GUARD_CYC ((`PSW_GUARD_NS + `PSW_SYS_NS - 1) / `PSW_SYS_NS)
// Address width of the write data store; it holds 16 words.
`define PSW_MEM_AW 4
`endif

/* core/psw_store.v */
// Purpose: Small word store holding the burst's data and byte masks.
// Assumes: One write and one registered read per clock.
// Notes: Read data come out of a register one cycle after the address.
`timescale 1ns/1ps
`include "psw_map.vh"
module psw_store (
  input wire SYS_CLK,
  input wire wr_en,
  input wire [`PSW_MEM_AW-1:0] wr_addr,
  input wire [17:0] wr_data,
  input wire [`PSW_MEM_AW-1:0] rd_addr,
  output reg [17:0] rd_data
);
  // Word storage: two mask bits above sixteen data bits.
  reg [17:0] mem [0:(1<<`PSW_MEM_AW)-1];

  // Write port and registered read port.
  always @(posedge SYS_CLK) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* core/psw_host.v */
// Purpose: Host controller issuing memory-array write bursts on the bus.
// Assumes: Device strobe is sampled during command cycles only.
// Notes: Bus clock is made here by a divider; it is not a second domain.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "psw_map.vh"
module psw_host (
  input wire SYS_CLK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  output reg CS_N,
  output reg CK_T,
  output reg CK_C,
  output reg [7:0] DQ_O,
  output reg DQ_OE,
  input wire STROBE_MASK_LINE_I,
  output reg STROBE_MASK_LINE_O,
  output reg STROBE_MASK_LINE_OE
);
  // Controller states.
  localparam S_IDLE = 3'd0;
  localparam S_SETUP = 3'd1;
  localparam S_CMD = 3'd2;
  localparam S_LAT = 3'd3;
  localparam S_DATA = 3'd4;
  localparam S_HOLD = 3'd5;

  reg [2:0] state_reg, state_next; // Main sequencer state.
  reg [15:0] ctrl_reg; // Burst type, latency count, word count.
  reg [31:0] addr_reg; // Target word address.
  reg done_reg; // Sticky burst-complete flag.
  reg dbl_reg; // Doubled latency seen on the strobe.
  reg [1:0] div_reg; // Bus clock half-period divider.
  reg [2:0] phase_reg; // Command byte index or half-cycle count.
  reg [4:0] lat_reg; // Remaining latency clock cycles.
  reg [7:0] left_reg; // Data words still to send.
  reg [47:0] ca_reg; // Assembled command-address word.
  reg [`PSW_MEM_AW-1:0] wptr_reg; // Store write pointer from software.
  reg [`PSW_MEM_AW-1:0] rptr_reg; // Store read pointer for the burst.
  reg [2:0] strobe_mask_line_sync_reg; // Strobe input synchroniser.
  wire [31:0] half_m1; // Divider reload, one less than a half period.
  wire [31:0] guard_cyc; // Idle-clock guard length in system cycles.
  reg [`PSW_MEM_AW:0] guard_reg; // Idle-clock guard counter.
  wire [17:0] word; // Next data word and its two masks.
  wire tick; // One bus clock half period has passed.
  wire strobe_hi; // Strobe high, settled over two stages.

  assign tick = (div_reg == 2'd0);
  assign strobe_hi = strobe_mask_line_sync_reg[1] & strobe_mask_line_sync_reg[2];
  // Timing counts are kept as full words and sliced where they are used.
  assign half_m1 = `PSW_HALF_CYC - 1;
  assign guard_cyc = `PSW_GUARD_CYC;

  // Data and mask words are kept in the store until the burst drains them.
  psw_store u_store (
    .SYS_CLK(SYS_CLK),
    .wr_en(WR && (ADDR == `PSW_ADDR_DATA)),
    .wr_addr(wptr_reg),
    .wr_data(WDATA[17:0]),
    .rd_addr(rptr_reg),
    .rd_data(word)
  );

  // Three flops on the strobe pin; only the later two are compared.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      strobe_mask_line_sync_reg <= 3'h0;
    end else begin
      strobe_mask_line_sync_reg <= {strobe_mask_line_sync_reg[1:0], STROBE_MASK_LINE_I};
    end
  end

  // Register port: writes steer the burst, reads show progress.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_reg <= `PSW_CTRL_RESET;
      addr_reg <= 32'h0;
      wptr_reg <= {`PSW_MEM_AW{1'b0}};
      RDATA <= 32'h0;
    end else begin
      if (WR && ADDR == `PSW_ADDR_CTRL) begin
        ctrl_reg <= WDATA[15:0];
      end else if (state_reg != S_IDLE) begin
        // The start bit self-clears once the burst is under way.
        ctrl_reg[`PSW_CTRL_GO] <= 1'b0;
      end
      if (WR && ADDR == `PSW_ADDR_ADDR) begin
        addr_reg <= WDATA;
        wptr_reg <= {`PSW_MEM_AW{1'b0}};
      end else if (WR && ADDR == `PSW_ADDR_DATA) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      // Read data stand only in the cycle after the strobe.
      if (RD) begin
        case (ADDR)
          `PSW_ADDR_CTRL: RDATA <= {16'h0, ctrl_reg};
          `PSW_ADDR_ADDR: RDATA <= addr_reg;
          // Busy also covers a start not yet taken, so a poll right
          // after the start never sees the previous burst's done flag with busy low.
          `PSW_ADDR_STAT: RDATA <= {29'h0, done_reg, dbl_reg,
            (state_reg != S_IDLE) | ctrl_reg[`PSW_CTRL_GO]};
          default: RDATA <= 32'h0;
        endcase
      end else begin
        RDATA <= 32'h0;
      end
    end
  end

  // Next-state logic of the sequencer.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        // a new burst only starts from deselected idle.
        if (ctrl_reg[`PSW_CTRL_GO]) begin
          state_next = S_SETUP;
        end
      end
      S_SETUP: begin
        if (guard_reg == 0) begin
          state_next = S_CMD;
        end
      end
      S_CMD: begin
        if (tick && phase_reg == 3'd5) begin
          state_next = S_LAT;
        end
      end
      S_LAT: begin
        if (tick && CK_T && lat_reg == 5'd1) begin
          state_next = S_DATA;
        end
      end
      S_DATA: begin
        // the clock keeps toggling until the last word has gone.
        if (tick && CK_T && left_reg == 8'd1) begin
          state_next = S_HOLD;
        end
      end
      S_HOLD: begin
        if (guard_reg == 0) begin
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Bus side: clock divider, command shifting, latency and data.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      state_reg <= S_IDLE;
      div_reg <= 2'd0;
      phase_reg <= 3'd0;
      lat_reg <= 5'd0;
      left_reg <= 8'd0;
      ca_reg <= 48'h0;
      rptr_reg <= {`PSW_MEM_AW{1'b0}};
      guard_reg <= {(`PSW_MEM_AW+1){1'b0}};
      dbl_reg <= 1'b0;
      done_reg <= 1'b0;
      CS_N <= 1'b1;
      CK_T <= 1'b0;
      CK_C <= 1'b1;
      DQ_O <= 8'h0;
      DQ_OE <= 1'b0;
      STROBE_MASK_LINE_O <= 1'b0;
      STROBE_MASK_LINE_OE <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg <= (div_reg == 2'd0) ? half_m1[1:0] : div_reg - 1'b1;
      if (guard_reg != 0) begin
        guard_reg <= guard_reg - 1'b1;
      end
      case (state_reg)
        S_IDLE: begin
          // the clock stays parked low while deselected.
          CK_T <= 1'b0;
          CK_C <= 1'b1;
          if (ctrl_reg[`PSW_CTRL_GO]) begin
            // write into memory space; burst type.
            ca_reg <= {1'b0, 1'b0, ctrl_reg[`PSW_CTRL_LINEAR],
              addr_reg[31:3], 13'h0, addr_reg[2:0]};
            CS_N <= 1'b0;
            done_reg <= 1'b0;
            dbl_reg <= 1'b0;
            rptr_reg <= {`PSW_MEM_AW{1'b0}};
            left_reg <= ctrl_reg[`PSW_CTRL_LEN_HI:`PSW_CTRL_LEN_LO];
            guard_reg <= guard_cyc[`PSW_MEM_AW:0];
            phase_reg <= 3'd0;
          end
        end
        S_SETUP: begin
          // first byte is presented before the first clock edge.
          DQ_O <= ca_reg[47:40];
          DQ_OE <= 1'b1;
        end
        S_CMD: begin
          // strobe belongs to the device; the host only listens.
          STROBE_MASK_LINE_OE <= 1'b0;
          if (strobe_hi) begin
            dbl_reg <= 1'b1;
          end
          if (tick) begin
            // Each edge takes the byte set up half a phase earlier.
            CK_T <= ~CK_T;
            CK_C <= ~CK_C;
            phase_reg <= phase_reg + 1'b1;
            if (phase_reg == 3'd5) begin
              // doubled count when the strobe asked for it.
              // the mask is always driven, as zero latency is not
              // offered by this controller.
              lat_reg <= (dbl_reg | strobe_hi) ?
                {ctrl_reg[`PSW_CTRL_LAT_HI:`PSW_CTRL_LAT_LO], 1'b0} :
                {1'b0, ctrl_reg[`PSW_CTRL_LAT_HI:`PSW_CTRL_LAT_LO]};
            end
          end else if (phase_reg != 3'd0) begin
            // Mid-way between edges the next byte goes out, so a byte
            // never changes on the edge that samples it.
            ca_reg <= {ca_reg[39:0], 8'h0};
            DQ_O <= ca_reg[39:32];
          end
        end
        S_LAT: begin
          if (tick) begin
            CK_T <= ~CK_T;
            CK_C <= ~CK_C;
            if (CK_T) begin
              lat_reg <= lat_reg - 1'b1;
            end
          end else begin
            // The last command byte has been taken; release the lanes.
            DQ_OE <= 1'b0;
          end
        end
        S_DATA: begin
          // host owns the strobe here, so no latency can appear.
          if (tick) begin
            CK_T <= ~CK_T;
            CK_C <= ~CK_C;
            if (CK_T) begin
              // A falling edge completes one word.
              left_reg <= left_reg - 1'b1;
              if (left_reg == 8'd1) begin
                // select rises later, with the clock idle low.
                guard_reg <= guard_cyc[`PSW_MEM_AW:0];
              end
            end
          end else if (!CK_T) begin
            // first byte set up mid-way before the rising edge.
            DQ_O <= word[15:8];
            STROBE_MASK_LINE_O <= word[17];
            DQ_OE <= 1'b1;
            STROBE_MASK_LINE_OE <= 1'b1;
          end else begin
            // second byte set up mid-way before the falling edge.
            DQ_O <= word[7:0];
            STROBE_MASK_LINE_O <= word[16];
            rptr_reg <= rptr_reg + 1'b1;
          end
        end
        S_HOLD: begin
          // Lanes are let go only after the last edge has sampled them.
          DQ_OE <= 1'b0;
          STROBE_MASK_LINE_OE <= 1'b0;
          CK_T <= 1'b0;
          CK_C <= 1'b1;
          if (guard_reg == 0) begin
            CS_N <= 1'b1;
            done_reg <= 1'b1;
          end
        end
        default: begin
          CS_N <= 1'b1;
        end
      endcase
    end
  end
endmodule

/* verification/psw_host_properties.sv */
// Purpose: Port assertions for the write-burst host controller.
// Assumes: Bound to psw_host and sees only its ports.
// Notes: The bus clock is watched as a level sampled by the system clock.
`timescale 1ns/1ps
module psw_host_properties (
  input wire SYS_CLK,
  input wire RST,
  input wire CS_N,
  input wire CK_T,
  input wire CK_C,
  input wire [7:0] DQ_O,
  input wire DQ_OE,
  input wire STROBE_MASK_LINE_O,
  input wire STROBE_MASK_LINE_OE
);
  // All checks share the system clock and its reset.
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  property p_ck_pair;
    CK_C == !CK_T;
  endproperty
  a_ck_pair: assert property (p_ck_pair) else $error("clock pair split");
  property p_open;
    $fell(CS_N) |-> !CK_T ##1 !CK_T;
  endproperty
  a_open: assert property (p_open) else $error("select fell on live clock");
  property p_close;
    $rose(CS_N) |-> !CK_T && !$past(CK_T);
  endproperty
  a_close: assert property (p_close) else $error("select rose on live clock");
  property p_park;
    CS_N |-> !CK_T && !DQ_OE && !STROBE_MASK_LINE_OE;
  endproperty
  a_park: assert property (p_park) else $error("bus active while deselected");
  property p_half;
    $changed(CK_T) |=> $stable(CK_T);
  endproperty
  a_half: assert property (p_half) else $error("clock half period short");
  // Data moving on a clock edge would break the centred placement.
  property p_centre;
    DQ_OE && $changed(CK_T) |-> $stable(DQ_O) && $stable(STROBE_MASK_LINE_O);
  endproperty
  a_centre: assert property (p_centre) else $error("data moved on edge");
  property p_ca_strobe;
    $fell(CS_N) |-> !STROBE_MASK_LINE_OE [*8];
  endproperty
  a_ca_strobe: assert property (p_ca_strobe) else $error("strobe taken in CA");
  property p_mask_data;
    STROBE_MASK_LINE_OE |-> DQ_OE;
  endproperty
  a_mask_data: assert property (p_mask_data) else $error("mask without data");
endmodule
bind psw_host psw_host_properties chk_u (.SYS_CLK(SYS_CLK), .RST(RST),
  .CS_N(CS_N), .CK_T(CK_T), .CK_C(CK_C), .DQ_O(DQ_O), .DQ_OE(DQ_OE),
  .STROBE_MASK_LINE_O(STROBE_MASK_LINE_O), .STROBE_MASK_LINE_OE(STROBE_MASK_LINE_OE));

/* verification/psw_dev_model.sv */
// Purpose: Behavioural memory device on the far side of the host.
// Assumes: Bytes are taken on each bus clock edge while selected.
// Notes: The array is small so that rollover is reached quickly.
`timescale 1ns/1ps
module psw_dev_model #(parameter int WORDS = 64) (
  input wire clk,
  input wire cs_n,
  input wire ck_t,
  input wire [7:0] dq,
  input wire strobe_mask_line_o,
  input wire strobe_mask_line_oe,
  input wire dbl,
  input wire [3:0] lat,
  output wire strobe_mask_line_i
);
  logic [15:0] mem [0:WORDS-1]; // Array contents, cleared at start.
  logic [47:0] ca; // Command word, first byte ends on top.
  logic [7:0] hi; // First byte of the word in flight.
  logic hi_keep; // Mask seen with the first byte.
  logic tgl = 1'b0; // Moving level while the strobe is released.
  logic [31:0] st, idx;
  int edges = 0;
  int n = 0;
  initial for (int i = 0; i < WORDS; i++) mem[i] = 16'h0000;
  always @(posedge clk) tgl <= ~tgl;
  // The device owns the strobe only while the command is on the bus.
  assign strobe_mask_line_i = (!cs_n && edges < 6) ? dbl : tgl;
  // A new select restarts framing, so a partial word is dropped.
  always @(negedge cs_n) begin
    edges = 0;
    n = 0;
  end
  // Each bus clock edge carries one byte.
  always @(ck_t) begin
    if (cs_n === 1'b0) begin
      if (edges < 6) begin
        ca = {ca[39:0], dq};
      end else if (edges >= 6 + lat * (dbl ? 4 : 2)
                   && ca[47:46] == 2'b00) begin
        st = {ca[44:16], ca[2:0]};
        if (ck_t) begin
          hi = dq;
          hi_keep = strobe_mask_line_oe && strobe_mask_line_o;
        end else begin
          // hybrid and legacy wrap agree within a single wrap.
          idx = ca[45] ? st + n : (st & ~32'h7) | ((st + n) & 32'h7);
          idx = idx % WORDS;
          if (!hi_keep) mem[idx][15:8] = hi;
          if (!(strobe_mask_line_oe && strobe_mask_line_o)) mem[idx][7:0] = dq;
          n++;
        end
      end
      edges++;
    end
  end
endmodule

/* verification/psw_host_tb.sv */
// Purpose: Self-checking bench for the write-burst host controller.
// Assumes: The device model answers every burst; masks are random.
// Notes: The expected array is rebuilt here from the burst rules.
`timescale 1ns/1ps
`include "psw_map.vh"
module psw_host_tb;
  logic SYS_CLK, RST, WR, RD, CS_N, CK_T, CK_C, DQ_OE;
  logic STROBE_MASK_LINE_I, STROBE_MASK_LINE_O, STROBE_MASK_LINE_OE, dbl, lin;
  logic [3:0] ADDR, lat;
  logic [7:0] DQ_O, len;
  logic [31:0] WDATA, RDATA, d, a, r, e;
  logic [15:0] exp_mem [0:63]; // Expected array image.
  logic [17:0] w;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h74b69669;
  int k;
  psw_host dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CS_N(CS_N), .CK_T(CK_T), .CK_C(CK_C),
    .DQ_O(DQ_O), .DQ_OE(DQ_OE), .STROBE_MASK_LINE_I(STROBE_MASK_LINE_I), .STROBE_MASK_LINE_O(STROBE_MASK_LINE_O),
    .STROBE_MASK_LINE_OE(STROBE_MASK_LINE_OE));
  psw_dev_model part_u (.clk(SYS_CLK), .cs_n(CS_N), .ck_t(CK_T), .dq(DQ_O),
    .strobe_mask_line_o(STROBE_MASK_LINE_O), .strobe_mask_line_oe(STROBE_MASK_LINE_OE), .dbl(dbl), .lat(lat),
    .strobe_mask_line_i(STROBE_MASK_LINE_I));
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  // A burst takes under a hundred cycles, so this only trips on a hang.
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk_reg(input logic [31:0] act, input logic [31:0] exp);
    comparisons++;
    if (act !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic chk_mem(input logic [15:0] act, input logic [15:0] exp);
    comparisons++;
    if (act !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  // Write strobe is left high so writes can follow back to back.
  task automatic reg_wr(input logic [3:0] ad, input logic [31:0] dt);
    ADDR <= ad;
    WDATA <= dt;
    WR <= 1'b1;
    @(posedge SYS_CLK);
  endtask
  task automatic reg_rd(input logic [3:0] ad, output logic [31:0] dt);
    WR <= 1'b0;
    RD <= 1'b1;
    ADDR <= ad;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    // Read data stand in this cycle and are taken at its closing edge.
    @(posedge SYS_CLK);
    dt = RDATA;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    RST = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 4'h0;
    WDATA = 32'h0;
    dbl = 1'b0;
    lat = 4'h2;
    for (k = 0; k < 64; k++) exp_mem[k] = 16'h0000;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    reg_rd(`PSW_ADDR_CTRL, d);
    chk_reg(d, {16'h0, `PSW_CTRL_RESET});
    reg_rd(4'hf, d);
    chk_reg(d, 32'h0);
    // Bursts cover both burst kinds, both latencies and array rollover.
    for (int t = 0; t < 6; t++) begin
      r = $random(seed);
      lin = t[0];
      dbl = t[1];
      lat = 4'h2 + {2'b00, r[6:5]};
      len = (t == 5) ? 8'h8 : 8'h1 + {5'h0, r[4:2]};
      a = (t == 5) ? {r[31:6], 6'h3d} : $random(seed);
      reg_wr(`PSW_ADDR_ADDR, a);
      reg_rd(`PSW_ADDR_ADDR, d);
      chk_reg(d, a);
      for (int i = 0; i < len; i++) begin
        w = 18'($random(seed));
        reg_wr(`PSW_ADDR_DATA, {14'h0, w});
        e = lin ? a + i : (a & ~32'h7) | ((a + i) & 32'h7);
        if (!w[17]) exp_mem[e[5:0]][15:8] = w[15:8];
        if (!w[16]) exp_mem[e[5:0]][7:0] = w[7:0];
      end
      reg_wr(`PSW_ADDR_CTRL, {16'h0, len, lat, 2'b00, lin, 1'b1});
      d = 32'h0;
      for (k = 0; k < 500 && !(d[2] === 1'b1 && d[0] === 1'b0); k++)
        reg_rd(`PSW_ADDR_STAT, d);
      chk_reg(d & 32'h7, {29'h0, 1'b1, dbl, 1'b0});
      for (k = 0; k < 64; k++) chk_mem(part_u.mem[k], exp_mem[k]);
      $display("test %0d lin %0d dbl %0d lat %0d len %0d done", t, lin, dbl,
        lat, len);
    end
    report_and_stop();
  end
endmodule
